// [logic/diag_pkg.sv]
// Constants and types for the input fault diagnostics register bank
package diag_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int MV_W = 16;
    localparam int EVT_W = 12;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIN_LIVE = 8'h42;
    localparam logic [7:0] IDX_MON_LIVE = 8'h43;
    localparam logic [7:0] IDX_SCAN = 8'h46;
    localparam logic [7:0] IDX_THRESH = 8'h47;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h50;
    localparam logic [7:0] IDX_EVT_MASK = 8'h51;

    localparam logic [7:0] LIVE_RST = 8'h00;
    localparam logic [7:0] SCAN_RST = 8'h00;
    localparam logic [7:0] THRESH_RST = 8'h37;
    localparam logic [EVT_W-1:0] EVT_RST = 12'h000;

    localparam int SCAN_CH1_BIT = 7;
    localparam int SCAN_CH2_BIT = 6;
    localparam int SCAN_SE_NEG_BIT = 5;
    localparam int SCAN_AC_BIT = 4;
    localparam int THR_TERM_LSB = 4;
    localparam int THR_VBAT_LSB = 0;
    localparam int PIN_OV_LSB = 4;

    localparam logic [MV_W-1:0] THR_STEP_MV = 16'h001E;
    localparam logic [3:0] THR_CFG_LO = 4'hA;
    localparam logic [3:0] THR_CFG_HI = 4'hD;

    typedef struct packed {
        logic ch1_scan_enable;
        logic ch2_scan_enable;
        logic include_single_ended_negative;
        logic include_ac_coupled;
    } scan_cfg_t;

    typedef struct packed {
        logic [3:0] terminal_short_threshold;
        logic [3:0] battery_short_threshold;
    } thresh_cfg_t;

    // Pin over-voltage: ch1 positive, ch1 negative, ch2 positive, ch2 negative
    typedef struct packed {
        logic [3:0] pin_ov;
        logic [7:0] monitor;
    } live_t;
endpackage

// [logic/thresh_decode.sv]
// Threshold code to millivolt decoder, registered
`timescale 1ns/1ns
module thresh_decode #(
    parameter int MV_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_code,
    input wire logic [MV_W-1:0] i_cfg_mv,
    output logic [MV_W-1:0] o_mv
);
    logic [MV_W-1:0] nxt_mv;

    always_comb
    begin
        if (i_code >= diag_pkg::THR_CFG_LO && i_code <= diag_pkg::THR_CFG_HI)
        begin
            nxt_mv = i_cfg_mv;
        end
        else
        begin
            // Listed codes and the gap 3-9 share one linear step
            nxt_mv = MV_W'(MV_W'(i_code) * diag_pkg::THR_STEP_MV);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_mv <= '0;
        end
        else
        begin
            o_mv <= nxt_mv;
        end
    end
endmodule

// [logic/input_fault_diag_regs.sv]
// APB register bank for input fault diagnostics, with event interrupt
`timescale 1ns/1ns
module input_fault_diag_regs (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [diag_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [diag_pkg::DATA_W-1:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [diag_pkg::DATA_W-1:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic [3:0] I_PIN_OV,
    input wire logic [7:0] I_MON_FAULT,
    input wire logic [diag_pkg::MV_W-1:0] I_TERM_CFG_MV,
    input wire logic [diag_pkg::MV_W-1:0] I_VBAT_CFG_MV,
    output logic O_CH1_SCAN_EN,
    output logic O_CH2_SCAN_EN,
    output logic O_INCL_SE_NEG,
    output logic O_INCL_AC,
    output logic [diag_pkg::MV_W-1:0] O_TERM_SHORT_MV,
    output logic [diag_pkg::MV_W-1:0] O_VBAT_SHORT_MV,
    output logic O_IRQ
);
    localparam int EW = diag_pkg::EVT_W;

    diag_pkg::live_t live_ff;
    diag_pkg::live_t live_in;
    diag_pkg::scan_cfg_t scan_ff;
    diag_pkg::thresh_cfg_t thresh_ff;
    logic [EW-1:0] status_ff;
    logic [EW-1:0] mask_ff;
    logic [EW-1:0] events;
    logic [EW-1:0] clr_bits;
    logic ready_ff;
    logic [diag_pkg::DATA_W-1:0] prdata_ff;
    logic pslverr_ff;
    logic access;
    logic xfer;
    logic wr_en;
    logic addr_ok;
    logic [7:0] reg_idx;
    logic [diag_pkg::DATA_W-1:0] rd_data;
    logic rd_err;

    // Bus decode
    assign access = I_PSEL && I_PENABLE;
    // One wait state: data is looked up in the first access cycle
    assign xfer = access && ready_ff;
    assign addr_ok = (I_PADDR[1:0] == 2'h0) && (I_PADDR[11:10] == 2'h0);
    assign reg_idx = I_PADDR[9:2];
    // Only the low byte lane strobe enables a write; other strobes are ignored
    assign wr_en = xfer && I_PWRITE && I_PSTRB[0] && addr_ok;

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            ready_ff <= 1'b0;
        end
        else
        begin
            ready_ff <= access && !ready_ff;
        end
    end

    always_comb
    begin
        rd_data = '0;
        rd_err = 1'b0;
        if (!addr_ok)
        begin
            rd_err = 1'b1;
        end
        else
        begin
            case (reg_idx)
                diag_pkg::IDX_PIN_LIVE:
                begin
                    // Low nibble reserved, reads zero
                    rd_data[7:4] = live_ff.pin_ov;
                end
                diag_pkg::IDX_MON_LIVE:
                begin
                    rd_data[7:0] = live_ff.monitor;
                end
                diag_pkg::IDX_SCAN:
                begin
                    rd_data[7:4] = scan_ff;
                end
                diag_pkg::IDX_THRESH:
                begin
                    rd_data[7:0] = thresh_ff;
                end
                diag_pkg::IDX_EVT_STATUS:
                begin
                    rd_data[EW-1:0] = status_ff;
                end
                diag_pkg::IDX_EVT_MASK:
                begin
                    rd_data[EW-1:0] = mask_ff;
                end
                default:
                begin
                    rd_err = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
        else if (access && !ready_ff)
        begin
            prdata_ff <= I_PWRITE ? '0 : rd_data;
            pslverr_ff <= rd_err;
        end
    end

    assign O_PREADY = ready_ff;
    assign O_PRDATA = prdata_ff;
    assign O_PSLVERR = pslverr_ff && ready_ff;

    // Live readback: sampled each cycle, bus writes never reach it
    assign live_in.pin_ov = I_PIN_OV;
    assign live_in.monitor = I_MON_FAULT;

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            live_ff <= {diag_pkg::LIVE_RST[3:0], diag_pkg::LIVE_RST};
        end
        else
        begin
            live_ff <= live_in;
        end
    end

    // Configuration registers
    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            scan_ff <= diag_pkg::SCAN_RST[7:4];
        end
        else if (wr_en && reg_idx == diag_pkg::IDX_SCAN)
        begin
            // Reserved low nibble is not stored
            scan_ff <= I_PWDATA[7:4];
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            thresh_ff <= diag_pkg::THRESH_RST;
        end
        else if (wr_en && reg_idx == diag_pkg::IDX_THRESH)
        begin
            thresh_ff <= I_PWDATA[7:0];
        end
    end

    assign O_CH1_SCAN_EN = scan_ff.ch1_scan_enable;
    assign O_CH2_SCAN_EN = scan_ff.ch2_scan_enable;
    assign O_INCL_SE_NEG = scan_ff.include_single_ended_negative;
    assign O_INCL_AC = scan_ff.include_ac_coupled;

    thresh_decode #(
        .MV_W(diag_pkg::MV_W)
    ) u_term_decode (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_code(thresh_ff.terminal_short_threshold),
        .i_cfg_mv(I_TERM_CFG_MV),
        .o_mv(O_TERM_SHORT_MV)
    );

    thresh_decode #(
        .MV_W(diag_pkg::MV_W)
    ) u_vbat_decode (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_code(thresh_ff.battery_short_threshold),
        .i_cfg_mv(I_VBAT_CFG_MV),
        .o_mv(O_VBAT_SHORT_MV)
    );

    // Event capture: a rising live bit latches until written one
    assign events = live_in & ~live_ff;
    assign clr_bits = (wr_en && reg_idx == diag_pkg::IDX_EVT_STATUS) ?
        I_PWDATA[EW-1:0] : '0;

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            status_ff <= diag_pkg::EVT_RST;
        end
        else
        begin
            // Set beats clear so a same-cycle event is kept
            status_ff <= (status_ff & ~clr_bits) | events;
        end
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            mask_ff <= diag_pkg::EVT_RST;
        end
        else if (wr_en && reg_idx == diag_pkg::IDX_EVT_MASK)
        begin
            mask_ff <= I_PWDATA[EW-1:0];
        end
    end

    assign O_IRQ = |(status_ff & mask_ff);

    // Checks
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);

    sequence s_read_of(logic [7:0] idx);
        access && !ready_ff && !I_PWRITE && addr_ok && reg_idx == idx
        ##1 ready_ff;
    endsequence

    sequence s_write_of(logic [7:0] idx);
        access && ready_ff && I_PWRITE && I_PSTRB[0] && addr_ok
        && reg_idx == idx;
    endsequence

    a_pin_live_track: assert property (
        ##1 live_ff.pin_ov == $past(I_PIN_OV))
        else $error("pin over-voltage live bits lag input");

    a_pin_reserved_zero: assert property (
        s_read_of(diag_pkg::IDX_PIN_LIVE) |->
        O_PRDATA[3:0] == 4'h0
        && O_PRDATA[7:4] == $past(live_ff.pin_ov))
        else $error("pin live read wrong");

    a_mon_thresh_read: assert property (
        s_read_of(diag_pkg::IDX_MON_LIVE) |->
        O_PRDATA[7:6] == $past(live_ff.monitor[7:6]))
        else $error("monitor threshold bits read wrong");

    a_voice_read: assert property (
        s_read_of(diag_pkg::IDX_MON_LIVE) |->
        O_PRDATA[5:4] == $past(live_ff.monitor[5:4]))
        else $error("voice activity bits read wrong");

    a_bias_fault_read: assert property (
        s_read_of(diag_pkg::IDX_MON_LIVE) |->
        O_PRDATA[3:0] == $past(live_ff.monitor[3:0])
        && O_PRDATA[31:8] == 24'h000000)
        else $error("bias fault bits read wrong");

    a_live_read_only: assert property (
        s_write_of(diag_pkg::IDX_MON_LIVE) |=>
        live_ff.monitor == $past(I_MON_FAULT))
        else $error("live register took a bus write");

    a_reset_values: assert property (
        $past(I_RST) |-> live_ff == 12'h000
        && thresh_ff == 8'h37 && scan_ff == 4'h0)
        else $error("reset values wrong");

    a_scan_enable_write: assert property (
        s_write_of(diag_pkg::IDX_SCAN) |=>
        O_CH1_SCAN_EN == $past(I_PWDATA[7])
        && O_CH2_SCAN_EN == $past(I_PWDATA[6]))
        else $error("scan enables not written");

    a_scan_incl_write: assert property (
        s_write_of(diag_pkg::IDX_SCAN) |=>
        O_INCL_SE_NEG == $past(I_PWDATA[5])
        && O_INCL_AC == $past(I_PWDATA[4]))
        else $error("scan include bits not written");

    a_scan_reserved_zero: assert property (
        s_read_of(diag_pkg::IDX_SCAN) |-> O_PRDATA[3:0] == 4'h0)
        else $error("scan reserved bits not zero");

    a_term_thresh_mv: assert property (
        !$past(I_RST) && (thresh_ff[7:4] < 4'hA || thresh_ff[7:4] > 4'hD)
        |=> O_TERM_SHORT_MV == 16'(16'($past(thresh_ff[7:4])) * 16'h001E))
        else $error("terminal short threshold wrong");

    a_vbat_thresh_mv: assert property (
        !$past(I_RST) && thresh_ff[3:0] >= 4'hA && thresh_ff[3:0] <= 4'hD
        |=> O_VBAT_SHORT_MV == $past(I_VBAT_CFG_MV))
        else $error("battery short configured level wrong");

    a_event_irq: assert property (
        mask_ff[11] && !I_PIN_OV[3] ##1 I_PIN_OV[3] |=> O_IRQ [*2])
        else $error("unmasked event did not raise interrupt");

    a_ready_one_wait: assert property (
        access && !ready_ff |=> O_PREADY ##1 !O_PREADY)
        else $error("bus answer timing wrong");
endmodule

// [sim/tb_input_fault_diag_regs.sv]
// Self-checking testbench for the input fault diagnostics register bank
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_input_fault_diag_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [diag_pkg::ADDR_W-1:0] paddr = '0;
    logic [diag_pkg::DATA_W-1:0] pwdata = '0;
    logic [3:0] pstrb = 4'hF;
    logic [diag_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] pin_ov = 4'h0;
    logic [7:0] mon = 8'h00;
    logic [diag_pkg::MV_W-1:0] term_cfg = 16'h0123;
    logic [diag_pkg::MV_W-1:0] vbat_cfg = 16'h0456;
    logic ch1, ch2, se_neg, ac, irq;
    logic [diag_pkg::MV_W-1:0] term_mv, vbat_mv;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int tests_run = 0;

    input_fault_diag_regs u_input_fault_diag_regs (
        .I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_PIN_OV(pin_ov), .I_MON_FAULT(mon),
        .I_TERM_CFG_MV(term_cfg), .I_VBAT_CFG_MV(vbat_cfg),
        .O_CH1_SCAN_EN(ch1), .O_CH2_SCAN_EN(ch2), .O_INCL_SE_NEG(se_neg),
        .O_INCL_AC(ac), .O_TERM_SHORT_MV(term_mv),
        .O_VBAT_SHORT_MV(vbat_mv), .O_IRQ(irq)
    );

    initial
    begin
        forever #50 clk = ~clk;
    end

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
        begin
            errors++;
            summarize;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input logic e_err);
        apb(1'b0, a, 32'h00000000);
        `CHK(rd, e)
        `CHK(err, e_err)
    endtask

    task automatic settle;
        repeat (3) @(negedge clk);
    endtask

    function automatic logic [15:0] mv(input logic [3:0] c,
                                       input logic [15:0] cfg);
        return (c >= 4'hA && c <= 4'hD) ? cfg : 16'(c) * 16'h001E;
    endfunction

    task automatic t_reset;
        rdchk(12'h108, 32'h00000000, 1'b0);
        rdchk(12'h10C, 32'h00000000, 1'b0);
        rdchk(12'h118, 32'h00000000, 1'b0);
        rdchk(12'h11C, 32'h00000037, 1'b0);
        `CHK({ch1, ch2, se_neg, ac}, 4'h0)
        `CHK(term_mv, 16'h005A)
        `CHK(vbat_mv, 16'h00D2)
        $display("done: reset values");
    endtask

    task automatic t_live;
        @(posedge clk);
        pin_ov <= 4'hA;
        mon <= 8'h5C;
        rdchk(12'h108, 32'h000000A0, 1'b0);
        rdchk(12'h10C, 32'h0000005C, 1'b0);
        // Reserved low nibble written only as zero
        apb(1'b1, 12'h108, 32'h000000F0);
        apb(1'b1, 12'h10C, 32'h000000FF);
        rdchk(12'h108, 32'h000000A0, 1'b0);
        rdchk(12'h10C, 32'h0000005C, 1'b0);
        $display("done: live readback");
    endtask

    // Live inputs stay high, so clearing must not be undone by a level
    task automatic t_irq;
        `CHK(irq, 1'b0)
        rdchk(12'h140, 32'h00000A5C, 1'b0);
        apb(1'b1, 12'h144, 32'h00000800);
        settle;
        `CHK(irq, 1'b1)
        apb(1'b1, 12'h140, 32'h00000A5C);
        settle;
        `CHK(irq, 1'b0)
        rdchk(12'h140, 32'h00000000, 1'b0);
        // A fresh rise of an unmasked pin flag must raise the line again
        @(posedge clk);
        pin_ov <= 4'h0;
        settle;
        `CHK(irq, 1'b0)
        @(posedge clk);
        pin_ov <= 4'hA;
        settle;
        `CHK(irq, 1'b1)
        rdchk(12'h140, 32'h00000A00, 1'b0);
        apb(1'b1, 12'h140, 32'h00000A00);
        settle;
        `CHK(irq, 1'b0)
        rdchk(12'h200, 32'h00000000, 1'b1);
        rdchk(12'h109, 32'h00000000, 1'b1);
        $display("done: interrupt and errors");
    endtask

    task automatic t_scan;
        apb(1'b1, 12'h118, 32'hFFFFFFFF);
        rdchk(12'h118, 32'h000000F0, 1'b0);
        `CHK({ch1, ch2, se_neg, ac}, 4'hF)
        apb(1'b1, 12'h118, 32'h00000050);
        settle;
        `CHK({ch1, ch2, se_neg, ac}, 4'h5)
        apb(1'b1, 12'h118, 32'h000000A0);
        settle;
        `CHK({ch1, ch2, se_neg, ac}, 4'hA)
        // Write without the low byte lane must leave the register alone
        @(posedge clk);
        pstrb <= 4'hE;
        apb(1'b1, 12'h118, 32'h00000000);
        pstrb <= 4'hF;
        settle;
        `CHK(err, 1'b0)
        `CHK({ch1, ch2, se_neg, ac}, 4'hA)
        $display("done: scan control");
    endtask

    task automatic t_thresh;
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, 12'h11C, {24'h000000, c[3:0], ~c[3:0]});
            settle;
            `CHK(term_mv, mv(c[3:0], term_cfg))
            `CHK(vbat_mv, mv(~c[3:0], vbat_cfg))
        end
        rdchk(12'h11C, 32'h000000F0, 1'b0);
        $display("done: thresholds");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Whole run is well under 2000 cycles; allow fifteen times that
    initial
    begin
        #3000000;
        errors++;
        summarize;
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_live;
        t_irq;
        t_scan;
        t_thresh;
        summarize;
    end
endmodule
